// ### src/tsr_consts.vh
// Notes on behaviour
// - Single write: open, select+write, index, one data byte, close; ack each byte.
// - Multi-byte write: many data bytes after the index, each one acknowledged.
// - Single read: index write, repeated open, select+read, one byte, host nack.
// - Multi-byte read: successive bytes; host acks all but the last one.
// - Every unit on the line is eight bits followed by an acknowledge slot.
// - Bits are shifted out and sampled most significant bit first.
// - No limit on the number of bytes between open and close.
// - Select byte not acknowledged: data line stays released high.
// - Data rising while clock high is a close; return to idle.
// - Strap to ground answers at address 0111111.
// - Strap to supply answers at address 0111000.
// - Strap via 15k gives 0111100, via 56k gives 0111110.
// - Index 01h is a read-only fixed identification code.
// - Index 02h: read-write high threshold, reset 00h.
// - Index 03h: read-write low threshold, reset 00h.
// - Index 04h control, reset 00h, fields as laid out below.
// - Index 05h read-only status: below-low, above-high, busy; rest zero.
// - Index 06h reads reading bits 7 to 0.
// - Index 07h reads reading bits 15 to 8.
// - Register index is the low seven bits; top bit ignored.
// - Autoincrement bit set advances the pointer per data byte, else fixed.
// - Reading status clears below-low and above-high flags.
// - Threshold of 00h disables that threshold's flag.
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH

// ==========================================================
// Register indices
`define TSR_IDX_DEVICE_ID 7'h01
`define TSR_IDX_HIGH_THR 7'h02
`define TSR_IDX_LOW_THR 7'h03
`define TSR_IDX_CONTROL 7'h04
`define TSR_IDX_STATUS 7'h05
`define TSR_IDX_READ_LO 7'h06
`define TSR_IDX_READ_HI 7'h07

// ==========================================================
// Reset values
`define TSR_RST_THR 8'h00
`define TSR_RST_CONTROL 8'h00

// ==========================================================
// Control fields
`define TSR_CTL_SLOW_RATE 7
`define TSR_CTL_COHERENT 6
`define TSR_CTL_AVG_HI 5
`define TSR_CTL_AVG_LO 4
`define TSR_CTL_AUTOINC 3
`define TSR_CTL_CONTINUOUS 2
`define TSR_CTL_STALL_GUARD_OFF 1
`define TSR_CTL_ONE_SHOT 0

// ==========================================================
// Status fields
`define TSR_STS_BELOW_LOW 2
`define TSR_STS_ABOVE_HIGH 1
`define TSR_STS_BUSY 0

// ==========================================================
// Strap codes and bus addresses
`define TSR_STRAP_GND 2'h0
`define TSR_STRAP_VDD 2'h1
`define TSR_STRAP_R15K 2'h2
`define TSR_STRAP_R56K 2'h3
`define TSR_ADDR_GND 7'h3F
`define TSR_ADDR_VDD 7'h38
`define TSR_ADDR_R15K 7'h3C
`define TSR_ADDR_R56K 7'h3E

`endif

// ### src/tsr_sync.v
`timescale 1ns/1ps
module tsr_sync #(
	parameter WIDTH = 4,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Async inputs and filtered levels
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] level
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg s1_ff;
			reg s2_ff;
			reg s3_ff;
			reg lvl_ff;
			always @(posedge clk) begin
				if (!rst_n) begin
					s1_ff <= INIT[i];
					s2_ff <= INIT[i];
					s3_ff <= INIT[i];
					lvl_ff <= INIT[i];
				end else begin
					s1_ff <= async_in[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					// Change counts once stages two and three agree
					if (s2_ff == s3_ff) begin
						lvl_ff <= s3_ff;
					end
				end
			end
			assign level[i] = lvl_ff;
		end
	endgenerate
endmodule // tsr_sync

// ### src/tsr_port.v
`timescale 1ns/1ps
`include "tsr_consts.vh"
module tsr_port #(
	// Arbitrary identification value
	parameter [7:0] DEVICE_ID = 8'h5C
) (
	// Clock and reset
	input wire CLOCK,
	input wire RESET_N,
	// Two-wire bus
	input wire SCL_IN,
	input wire SDA_IN,
	output wire SDA_OUT,
	output wire SDA_OE,
	// Address strap
	input wire [1:0] ADDR_STRAP,
	// Conversion side
	input wire [15:0] READING,
	input wire READING_VALID,
	input wire BELOW_LOW_EVENT,
	input wire ABOVE_HIGH_EVENT,
	input wire CONV_BUSY,
	// Configuration out
	output wire [7:0] HIGH_THRESHOLD,
	output wire [7:0] LOW_THRESHOLD,
	output wire [7:0] CONTROL,
	output wire ONE_SHOT_PULSE,
	output wire [2:0] STATUS_FLAGS
);
	// ==========================================================
	// States
	localparam [8:0] ST_IDLE = 9'h001;
	localparam [8:0] ST_ADDR = 9'h002;
	localparam [8:0] ST_AACK = 9'h004;
	localparam [8:0] ST_INDEX = 9'h008;
	localparam [8:0] ST_IACK = 9'h010;
	localparam [8:0] ST_WDATA = 9'h020;
	localparam [8:0] ST_WACK = 9'h040;
	localparam [8:0] ST_TX = 9'h080;
	localparam [8:0] ST_HACK = 9'h100;

	// ==========================================================
	// Input synchronisers
	wire [3:0] lvl;
	tsr_sync #(.WIDTH(4), .INIT(4'hF)) u_sync (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.async_in({ADDR_STRAP, SDA_IN, SCL_IN}),
		.level(lvl)
	);
	wire scl = lvl[0];
	wire sda = lvl[1];
	reg scl_prev_ff;
	reg sda_prev_ff;
	wire scl_rise = scl & ~scl_prev_ff;
	wire scl_fall = ~scl & scl_prev_ff;
	wire bus_open = scl & scl_prev_ff & sda_prev_ff & ~sda;
	wire bus_close = scl & scl_prev_ff & ~sda_prev_ff & sda;

	// ==========================================================
	// State
	reg [8:0] state_ff;
	reg [2:0] cnt_ff;
	reg [7:0] shift_ff;
	reg done_ff;
	reg rw_ff;
	reg host_ack_ff;
	reg [7:0] tx_ff;
	reg oe_ff;
	reg out_ff;
	reg [6:0] ptr_ff;
	reg [6:0] my_addr_ff;
	reg [7:0] high_thr_ff;
	reg [7:0] low_thr_ff;
	reg [7:0] control_ff;
	reg one_shot_ff;
	reg below_ff;
	reg above_ff;
	reg busy_ff;
	reg [15:0] reading_ff;
	reg [7:0] hi_shadow_ff;
	reg shadow_held_ff;

	// ==========================================================
	// Read data
	reg [7:0] rd_data;
	always @* begin
		case (ptr_ff)
			`TSR_IDX_DEVICE_ID: rd_data = DEVICE_ID;
			`TSR_IDX_HIGH_THR: rd_data = high_thr_ff;
			`TSR_IDX_LOW_THR: rd_data = low_thr_ff;
			`TSR_IDX_CONTROL: rd_data = control_ff;
			`TSR_IDX_STATUS: rd_data = {5'h00, below_ff, above_ff,
				busy_ff};
			`TSR_IDX_READ_LO: rd_data = reading_ff[7:0];
			`TSR_IDX_READ_HI: rd_data = shadow_held_ff ? hi_shadow_ff :
				reading_ff[15:8];
			default: rd_data = 8'h00;
		endcase
	end

	wire autoinc = control_ff[`TSR_CTL_AUTOINC];
	wire [6:0] ptr_inc = ptr_ff + 7'h01;
	wire [7:0] rx_byte = {shift_ff[6:0], sda};
	wire load_tx = (state_ff == ST_AACK && rw_ff && scl_fall) ||
		(state_ff == ST_HACK && host_ack_ff && scl_fall);
	wire wr_strobe = (state_ff == ST_WDATA) && done_ff && scl_fall;
	wire rd_status = load_tx && (ptr_ff == `TSR_IDX_STATUS);

	// ==========================================================
	// Bus engine
	always @(posedge CLOCK) begin
		if (!RESET_N) begin
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
			state_ff <= ST_IDLE;
			cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			done_ff <= 1'b0;
			rw_ff <= 1'b0;
			host_ack_ff <= 1'b0;
			tx_ff <= 8'h00;
			oe_ff <= 1'b0;
			out_ff <= 1'b0;
			ptr_ff <= 7'h00;
		end else begin
			scl_prev_ff <= scl;
			sda_prev_ff <= sda;
			out_ff <= 1'b0;
			if (bus_open) begin
				// Open or repeated open
				state_ff <= ST_ADDR;
				cnt_ff <= 3'h0;
				done_ff <= 1'b0;
				oe_ff <= 1'b0;
			end else if (bus_close) begin
				state_ff <= ST_IDLE;
				done_ff <= 1'b0;
				oe_ff <= 1'b0;
			end else begin
				case (state_ff)
					ST_IDLE: begin
						oe_ff <= 1'b0;
					end
					ST_ADDR, ST_INDEX, ST_WDATA: begin
						if (scl_rise && !done_ff) begin
							// MSB first, eight bits
							shift_ff <= rx_byte;
							cnt_ff <= cnt_ff + 3'h1;
							if (cnt_ff == 3'h7) begin
								done_ff <= 1'b1;
							end
						end else if (scl_fall && done_ff) begin
							done_ff <= 1'b0;
							if (state_ff == ST_ADDR) begin
								if (shift_ff[7:1] == my_addr_ff) begin
									rw_ff <= shift_ff[0];
									oe_ff <= 1'b1;
									state_ff <= ST_AACK;
								end else begin
									oe_ff <= 1'b0;
									state_ff <= ST_IDLE;
								end
							end else if (state_ff == ST_INDEX) begin
								ptr_ff <= shift_ff[6:0];
								oe_ff <= 1'b1;
								state_ff <= ST_IACK;
							end else begin
								if (autoinc) begin
									ptr_ff <= ptr_inc;
								end
								oe_ff <= 1'b1;
								state_ff <= ST_WACK;
							end
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							cnt_ff <= 3'h0;
							if (rw_ff) begin
								tx_ff <= rd_data;
								oe_ff <= ~rd_data[7];
								state_ff <= ST_TX;
								if (autoinc) begin
									ptr_ff <= ptr_inc;
								end
							end else begin
								oe_ff <= 1'b0;
								state_ff <= ST_INDEX;
							end
						end
					end
					ST_IACK, ST_WACK: begin
						if (scl_fall) begin
							oe_ff <= 1'b0;
							cnt_ff <= 3'h0;
							state_ff <= ST_WDATA;
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							cnt_ff <= cnt_ff + 3'h1;
							if (cnt_ff == 3'h7) begin
								oe_ff <= 1'b0;
								state_ff <= ST_HACK;
							end else begin
								tx_ff <= {tx_ff[6:0], 1'b0};
								oe_ff <= ~tx_ff[6];
							end
						end
					end
					ST_HACK: begin
						if (scl_rise) begin
							host_ack_ff <= ~sda;
						end else if (scl_fall) begin
							cnt_ff <= 3'h0;
							if (host_ack_ff) begin
								tx_ff <= rd_data;
								oe_ff <= ~rd_data[7];
								state_ff <= ST_TX;
								if (autoinc) begin
									ptr_ff <= ptr_inc;
								end
							end else begin
								oe_ff <= 1'b0;
								state_ff <= ST_IDLE;
							end
						end
					end
					default: begin
						state_ff <= ST_IDLE;
						oe_ff <= 1'b0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Address strap, tracked from the filtered level
	// Sync stages sit at their reset value while reset is held
	always @(posedge CLOCK) begin
		case (lvl[3:2])
			`TSR_STRAP_GND: my_addr_ff <= `TSR_ADDR_GND;
			`TSR_STRAP_VDD: my_addr_ff <= `TSR_ADDR_VDD;
			`TSR_STRAP_R15K: my_addr_ff <= `TSR_ADDR_R15K;
			default: my_addr_ff <= `TSR_ADDR_R56K;
		endcase
	end

	// ==========================================================
	// Register file
	always @(posedge CLOCK) begin
		if (!RESET_N) begin
			high_thr_ff <= `TSR_RST_THR;
			low_thr_ff <= `TSR_RST_THR;
			control_ff <= `TSR_RST_CONTROL;
			one_shot_ff <= 1'b0;
		end else begin
			one_shot_ff <= 1'b0;
			if (wr_strobe) begin
				case (ptr_ff)
					`TSR_IDX_HIGH_THR: high_thr_ff <= shift_ff;
					`TSR_IDX_LOW_THR: low_thr_ff <= shift_ff;
					`TSR_IDX_CONTROL: begin
						control_ff <= shift_ff;
						one_shot_ff <= shift_ff[`TSR_CTL_ONE_SHOT];
					end
					default: begin
						// Read-only or unmapped: acked, no effect
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Status flags and reading
	always @(posedge CLOCK) begin
		if (!RESET_N) begin
			below_ff <= 1'b0;
			above_ff <= 1'b0;
			busy_ff <= 1'b0;
			reading_ff <= 16'h0000;
			hi_shadow_ff <= 8'h00;
			shadow_held_ff <= 1'b0;
		end else begin
			busy_ff <= CONV_BUSY;
			// Set wins over the read clear
			below_ff <= (below_ff & ~rd_status) |
				(BELOW_LOW_EVENT & (low_thr_ff != 8'h00));
			above_ff <= (above_ff & ~rd_status) |
				(ABOVE_HIGH_EVENT & (high_thr_ff != 8'h00));
			if (READING_VALID) begin
				reading_ff <= READING;
			end
			// Coherent read: low byte read freezes the high byte
			if (load_tx && ptr_ff == `TSR_IDX_READ_LO &&
				control_ff[`TSR_CTL_COHERENT]) begin
				hi_shadow_ff <= reading_ff[15:8];
				shadow_held_ff <= 1'b1;
			end else if (load_tx && ptr_ff == `TSR_IDX_READ_HI) begin
				shadow_held_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Outputs
	assign SDA_OUT = out_ff;
	assign SDA_OE = oe_ff;
	assign HIGH_THRESHOLD = high_thr_ff;
	assign LOW_THRESHOLD = low_thr_ff;
	assign CONTROL = control_ff;
	assign ONE_SHOT_PULSE = one_shot_ff;
	assign STATUS_FLAGS = {below_ff, above_ff, busy_ff};
endmodule // tsr_port

// ### dv/tsr_host.sv
`timescale 1ns/1ps
// ==============================
// Bus host model, line pulled up
module tsr_host (
	// Device drive
	input wire oe,
	// Bus lines
	output logic scl,
	output wire sda
);
	logic drv = 1'b1;
	initial scl = 1'b1;
	assign sda = drv & ~oe;
	task automatic bit9(input logic b, output logic r);
		#140 drv = b;
		#60 scl = 1'b1;
		#90 r = sda;
		#10 scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) bit9(d[i], q[i]);
		bit9(a, k);
	endtask
	task automatic open;
		drv = 1'b1;
		#140 scl = 1'b1;
		#100 drv = 1'b0;
		#100 scl = 1'b0;
	endtask
	task automatic close;
		#140 drv = 1'b0;
		#60 scl = 1'b1;
		#100 drv = 1'b1;
		#200;
	endtask
endmodule // tsr_host

// ### dv/tsr_port_sva.sv
`timescale 1ns/1ps
// ==============================
// Port checker
module tsr_chk (
	input wire CLOCK,
	input wire RESET_N,
	input wire SCL_IN,
	input wire SDA_OUT,
	input wire SDA_OE,
	input wire BELOW_LOW_EVENT,
	input wire ABOVE_HIGH_EVENT,
	input wire CONV_BUSY,
	input wire [7:0] HIGH_THRESHOLD,
	input wire [7:0] LOW_THRESHOLD,
	input wire [7:0] CONTROL,
	input wire ONE_SHOT_PULSE,
	input wire [2:0] STATUS_FLAGS
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	a_reset_clear:
	assert property ($rose(RESET_N) |-> !SDA_OE && CONTROL == 8'h00
		&& HIGH_THRESHOLD == 8'h00 && LOW_THRESHOLD == 8'h00)
		else $error("registers not cleared by reset");
	a_busy_follow:
	assert property ($past(RESET_N) |-> STATUS_FLAGS[0] == $past(CONV_BUSY))
		else $error("busy flag does not follow input");
	a_high_gate:
	assert property ($rose(STATUS_FLAGS[1]) |-> $past(ABOVE_HIGH_EVENT)
		&& $past(HIGH_THRESHOLD) != 8'h00)
		else $error("above-high flag set without cause");
	a_low_gate:
	assert property ($rose(STATUS_FLAGS[2]) |-> $past(BELOW_LOW_EVENT)
		&& $past(LOW_THRESHOLD) != 8'h00)
		else $error("below-low flag set without cause");
	a_shot_pulse:
	assert property (ONE_SHOT_PULSE |-> CONTROL[0] ##1 !ONE_SHOT_PULSE)
		else $error("one-shot pulse malformed");
	a_regs_quiet:
	assert property (!$stable({HIGH_THRESHOLD, LOW_THRESHOLD, CONTROL})
		|-> !SCL_IN)
		else $error("register changed outside bus low phase");
	a_oe_scl_low:
	assert property (!$stable(SDA_OE) |-> !SCL_IN)
		else $error("data drive changed while clock high");
	a_oe_hold:
	assert property ($rose(SDA_OE) |=> SDA_OE [*8])
		else $error("data drive too short");
	a_sda_low:
	assert property (SDA_OUT == 1'b0)
		else $error("open drain drives high");
endmodule // tsr_chk
bind tsr_port tsr_chk tsr_chk_i (.CLOCK(CLOCK), .RESET_N(RESET_N),
	.SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.BELOW_LOW_EVENT(BELOW_LOW_EVENT), .ABOVE_HIGH_EVENT(ABOVE_HIGH_EVENT),
	.CONV_BUSY(CONV_BUSY), .HIGH_THRESHOLD(HIGH_THRESHOLD),
	.LOW_THRESHOLD(LOW_THRESHOLD), .CONTROL(CONTROL),
	.ONE_SHOT_PULSE(ONE_SHOT_PULSE), .STATUS_FLAGS(STATUS_FLAGS));

// ### dv/tb.sv
`timescale 1ns/1ps
// ==============================
// Bench top
module tb;
	// Arbitrary identification value
	localparam [7:0] ID = 8'h5C;
	logic CLOCK = 1'b0;
	logic RESET_N = 1'b0;
	logic [1:0] ADDR_STRAP = 2'h0;
	logic [15:0] READING = 16'h0000;
	logic READING_VALID = 1'b0;
	logic BELOW_LOW_EVENT = 1'b0;
	logic ABOVE_HIGH_EVENT = 1'b0;
	logic CONV_BUSY = 1'b0;
	wire SCL_IN, SDA_IN, SDA_OUT, SDA_OE, ONE_SHOT_PULSE;
	wire [7:0] HIGH_THRESHOLD, LOW_THRESHOLD, CONTROL;
	wire [2:0] STATUS_FLAGS;
	int n_fail = 0;
	int n_compared = 0;
	logic [31:0] seed = 32'h0000_5206;
	logic [6:0] adr = 7'h3F;
	logic [7:0] q, r;
	logic k;
	always #10 CLOCK = ~CLOCK;
	tsr_port #(.DEVICE_ID(ID)) tsr_port_i (.CLOCK(CLOCK), .RESET_N(RESET_N),
		.SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
		.ADDR_STRAP(ADDR_STRAP), .READING(READING),
		.READING_VALID(READING_VALID), .BELOW_LOW_EVENT(BELOW_LOW_EVENT),
		.ABOVE_HIGH_EVENT(ABOVE_HIGH_EVENT), .CONV_BUSY(CONV_BUSY),
		.HIGH_THRESHOLD(HIGH_THRESHOLD), .LOW_THRESHOLD(LOW_THRESHOLD),
		.CONTROL(CONTROL), .ONE_SHOT_PULSE(ONE_SHOT_PULSE),
		.STATUS_FLAGS(STATUS_FLAGS));
	tsr_host tsr_host_i (.oe(SDA_OE), .scl(SCL_IN), .sda(SDA_IN));
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic [6:0] addr_of(input [1:0] s);
		addr_of = s == 2'h0 ? 7'h3F : s == 2'h1 ? 7'h38 :
			s == 2'h2 ? 7'h3C : 7'h3E;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic sb(input logic [7:0] d);
		tsr_host_i.xfer(d, 1'b1, q, k);
		chk({7'h00, k}, 8'h00);
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d[$]);
		tsr_host_i.open;
		sb({adr, 1'b0});
		sb(i);
		foreach (d[j]) sb(d[j]);
		tsr_host_i.close;
	endtask
	task automatic rd_open(input logic [7:0] i);
		tsr_host_i.open;
		sb({adr, 1'b0});
		sb(i);
		tsr_host_i.open;
		sb({adr, 1'b1});
	endtask
	task automatic rd(input logic last, input logic [7:0] exp);
		tsr_host_i.xfer(8'hFF, last, r, k);
		chk(r, exp);
		if (last) tsr_host_i.close;
	endtask
	task automatic rst(input logic [1:0] s);
		@(posedge CLOCK);
		ADDR_STRAP <= s;
		RESET_N <= 1'b0;
		repeat (20) @(posedge CLOCK);
		RESET_N <= 1'b1;
		repeat (6) @(posedge CLOCK);
		adr = addr_of(s);
	endtask
	task automatic events;
		@(posedge CLOCK);
		ABOVE_HIGH_EVENT <= 1'b1;
		BELOW_LOW_EVENT <= 1'b1;
		@(posedge CLOCK);
		ABOVE_HIGH_EVENT <= 1'b0;
		BELOW_LOW_EVENT <= 1'b0;
	endtask
	task automatic end_of_test;
		if (n_fail == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#1_000_000;
		n_fail++;
		end_of_test;
	end
	initial begin
		rst(2'h0);
		rd_open(8'h01);
		rd(1'b0, ID);
		rd(1'b1, ID);
		for (int j = 2; j < 5; j++) begin
			rd_open(j[7:0]);
			rd(1'b1, 8'h00);
		end
		repeat (4) begin
			seed = lfsr(seed);
			wr(8'h02, '{seed[7:0]});
			wr(8'h83, '{seed[15:8]});
			chk(HIGH_THRESHOLD, seed[7:0]);
			chk(LOW_THRESHOLD, seed[15:8]);
			rd_open(8'h02);
			rd(1'b1, seed[7:0]);
		end
		wr(8'h02, '{8'h11, 8'h22});
		chk(HIGH_THRESHOLD, 8'h22);
		chk(LOW_THRESHOLD, seed[15:8]);
		wr(8'h01, '{8'hFF});
		wr(8'h05, '{8'hFF});
		rd_open(8'h01);
		rd(1'b1, ID);
		wr(8'h04, '{8'h09});
		chk(CONTROL, 8'h09);
		wr(8'h02, '{8'h12, 8'h34, 8'h08});
		chk(CONTROL, 8'h08);
		rd_open(8'h02);
		rd(1'b0, 8'h12);
		rd(1'b0, 8'h34);
		rd(1'b1, 8'h08);
		@(posedge CLOCK);
		READING <= seed[31:16];
		READING_VALID <= 1'b1;
		CONV_BUSY <= 1'b1;
		@(posedge CLOCK);
		READING_VALID <= 1'b0;
		rd_open(8'h06);
		rd(1'b0, seed[23:16]);
		rd(1'b1, seed[31:24]);
		events;
		@(posedge CLOCK);
		#1 chk({5'h00, STATUS_FLAGS}, 8'h07);
		rd_open(8'h05);
		rd(1'b1, 8'h07);
		rd_open(8'h05);
		rd(1'b1, 8'h01);
		@(posedge CLOCK);
		CONV_BUSY <= 1'b0;
		wr(8'h02, '{8'h00, 8'h00});
		events;
		rd_open(8'h05);
		rd(1'b1, 8'h00);
		tsr_host_i.open;
		tsr_host_i.xfer({adr ^ 7'h01, 1'b0}, 1'b1, q, k);
		chk({7'h00, k}, 8'h01);
		tsr_host_i.close;
		for (int s = 1; s < 4; s++) begin
			rst(s[1:0]);
			chk(CONTROL, 8'h00);
			rd_open(8'h01);
			rd(1'b1, ID);
		end
		end_of_test;
	end
endmodule // tb
